// ---- core/iopfc_cfg.sv ----
// Purpose: Interrupt tagging, IOAPIC enable, pin routing and prefetch control registers.
// Assumes: Single 200 MHz clock, asynchronous active-low reset, plain register port.
// Notes:   Read data appear one cycle after the read strobe; unmapped reads give zero.
// Summary of operation
// RL1: NMI tag enable sets message type bit3.
// RL2: INTR tag enable sets message type bit3.
// RL3: Pin low when route, mask, GPIO low.
// RL4: GPIO 28..31 map to pins A..D.
// RL5: Raw pad GPIO level, no inversion.
// RL6: Share control sends GPIO assertions to D.
// RL7: IOAPIC off: window ignored, PIC messages direct.
// RL8: IOAPIC on: PIC INTR goes via table.
// RL9: Software keeps must-be-low bits zero.
// RL10: Software clears second misc register at init.
// RL11: Three bits per master, packed in order.
// RL12: Group seven is peripheral pair; 31:24 reserved.
// RL13: Config, misc A, prefetch reset to zero.
// RL14: Share control puts all sources on D.
// RL15: Prefetch disable: one or two doublewords.
// RL16: Host request discards prefetch data on flag.
// RL17: Reserved bits read zero, ignore writes.
`timescale 1ns/100ps
module iopfc_cfg (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [31:0] reg_rdata_o,
    input  wire logic        pic_intr_i,
    input  wire logic        local_nmi_i,
    input  wire logic        apic_msg_valid_i,
    input  wire logic [3:0]  apic_msg_type_i,
    output logic             msg_valid_o,
    output logic      [3:0]  msg_type_o,
    output logic             apic_pic_intr_o,
    input  wire logic        apic_win_access_i,
    output logic             apic_win_accept_o,
    input  wire logic [3:0]  redir_mask_i,
    input  wire logic [3:0]  gpio_raw_i,
    input  wire logic [3:0]  int_src_i,
    input  wire logic        share_all_on_pin_d_i,
    output logic      [3:0]  pci_int_pins_n_o,
    output logic      [3:0]  pci_int_pins_n_oe_o,
    input  wire logic        rd_req_i,
    input  wire logic [2:0]  rd_master_i,
    input  wire logic        rd_burst_i,
    output logic      [1:0]  rd_dwords_o,
    output logic             rd_prefetch_o,
    input  wire logic        host_req_on_pci_i,
    input  wire logic        peer_req_i,
    input  wire logic [2:0]  peer_master_i,
    output logic      [7:0]  pf_discard_o,
    output logic      [7:0]  pf_disable_o
);
    logic [7:0]  tag_cfg_r;
    logic [7:0]  tag_cfg_nxt;
    logic [7:0]  route_cfg_r;
    logic [7:0]  route_cfg_nxt;
    logic [15:0] misc_a_r;
    logic [15:0] misc_a_nxt;
    logic [15:0] misc_b_r;
    logic [15:0] misc_b_nxt;
    logic [31:0] pf_lo_r;
    logic [31:0] pf_lo_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    logic        apic_en;
    logic [7:0]  dis_host;
    logic [7:0]  dis_peer;

    // Register file. Masks drop writes to reserved bits.
    always_comb begin
        tag_cfg_nxt   = tag_cfg_r;
        route_cfg_nxt = route_cfg_r;
        misc_a_nxt    = misc_a_r;
        misc_b_nxt    = misc_b_r;
        pf_lo_nxt     = pf_lo_r;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                iopfc_pkg::OFS_TAG_CFG: begin
                    tag_cfg_nxt = reg_wdata_i[7:0] & iopfc_pkg::WMASK_TAG_CFG; // RL17
                end
                iopfc_pkg::OFS_ROUTE_CFG: begin
                    route_cfg_nxt = reg_wdata_i[7:0] & iopfc_pkg::WMASK_ROUTE_CFG; // RL17
                end
                iopfc_pkg::OFS_MISC_A: begin
                    misc_a_nxt = reg_wdata_i[15:0] & iopfc_pkg::WMASK_MISC_A; // RL17
                end
                iopfc_pkg::OFS_MISC_B: begin
                    misc_b_nxt = reg_wdata_i[15:0] & iopfc_pkg::WMASK_MISC_B;
                end
                iopfc_pkg::OFS_PF_LO: begin
                    pf_lo_nxt = reg_wdata_i & iopfc_pkg::WMASK_PF_LO; // RL12 RL17
                end
                default: begin
                end
            endcase
        end
    end

    // Reads of unmapped offsets return zero rather than stalling the port.
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                iopfc_pkg::OFS_TAG_CFG: begin
                    rdata_nxt = {24'h00_0000, tag_cfg_r};
                end
                iopfc_pkg::OFS_ROUTE_CFG: begin
                    rdata_nxt = {24'h00_0000, route_cfg_r};
                end
                iopfc_pkg::OFS_MISC_A: begin
                    rdata_nxt = {16'h0000, misc_a_r};
                end
                iopfc_pkg::OFS_MISC_B: begin
                    rdata_nxt = {16'h0000, misc_b_r};
                end
                iopfc_pkg::OFS_PF_LO: begin
                    rdata_nxt = pf_lo_r;
                end
                default: begin
                    rdata_nxt = 32'h0000_0000;
                end
            endcase
        end
    end

    // Misc B resets nonzero; the setup code is expected to clear it.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tag_cfg_r   <= iopfc_pkg::RST_TAG_CFG; // RL13
            route_cfg_r <= iopfc_pkg::RST_ROUTE_CFG; // RL13
            misc_a_r    <= iopfc_pkg::RST_MISC_A; // RL13
            misc_b_r    <= iopfc_pkg::RST_MISC_B;
            pf_lo_r     <= iopfc_pkg::RST_PF_LO; // RL13
            rdata_r     <= 32'h0000_0000;
        end else begin
            tag_cfg_r   <= tag_cfg_nxt;
            route_cfg_r <= route_cfg_nxt;
            misc_a_r    <= misc_a_nxt;
            misc_b_r    <= misc_b_nxt;
            pf_lo_r     <= pf_lo_nxt;
            rdata_r     <= rdata_nxt;
        end
    end

    assign reg_rdata_o = rdata_r;
    assign apic_en     = route_cfg_r[iopfc_pkg::BIT_APIC_EN];

    // Upstream interrupt messages. IOAPIC messages win the link; local
    // requests wait in pending flags, where a new event beats the clear.
    logic       pic_q_r;
    logic       pic_q_nxt;
    logic       nmi_q_r;
    logic       nmi_q_nxt;
    logic       intr_pend_r;
    logic       intr_pend_nxt;
    logic       nmi_pend_r;
    logic       nmi_pend_nxt;
    logic       msg_valid_r;
    logic       msg_valid_nxt;
    logic [3:0] msg_type_r;
    logic [3:0] msg_type_nxt;
    logic       pic_direct;

    assign pic_direct = pic_intr_i & ~apic_en; // RL7 RL8

    always_comb begin
        pic_q_nxt     = pic_direct;
        nmi_q_nxt     = local_nmi_i;
        intr_pend_nxt = intr_pend_r;
        nmi_pend_nxt  = nmi_pend_r;
        msg_valid_nxt = 1'b0;
        msg_type_nxt  = msg_type_r;
        // NMI goes ahead of INTR, so a burst of PIC edges cannot hold it back.
        if (apic_msg_valid_i) begin
            msg_valid_nxt = 1'b1;
            msg_type_nxt  = apic_msg_type_i;
        end else if (nmi_pend_r) begin
            msg_valid_nxt = 1'b1;
            msg_type_nxt  = iopfc_pkg::MSG_TYPE_NMI;
            msg_type_nxt[iopfc_pkg::MSG_TAG_BIT] = tag_cfg_r[iopfc_pkg::BIT_NMI_TAG]; // RL1
            nmi_pend_nxt  = 1'b0;
        end else if (intr_pend_r && !apic_en) begin
            msg_valid_nxt = 1'b1;
            msg_type_nxt  = iopfc_pkg::MSG_TYPE_INTR;
            msg_type_nxt[iopfc_pkg::MSG_TAG_BIT] = tag_cfg_r[iopfc_pkg::BIT_INTR_TAG]; // RL2
            intr_pend_nxt = 1'b0;
        end
        // A request still pending when the IOAPIC takes over is dropped.
        if (apic_en) begin
            intr_pend_nxt = 1'b0; // RL8
        end
        if (pic_direct && !pic_q_r) begin
            intr_pend_nxt = 1'b1; // RL7
        end
        if (local_nmi_i && !nmi_q_r) begin
            nmi_pend_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pic_q_r     <= 1'b0;
            nmi_q_r     <= 1'b0;
            intr_pend_r <= 1'b0;
            nmi_pend_r  <= 1'b0;
            msg_valid_r <= 1'b0;
            msg_type_r  <= 4'h0;
        end else begin
            pic_q_r     <= pic_q_nxt;
            nmi_q_r     <= nmi_q_nxt;
            intr_pend_r <= intr_pend_nxt;
            nmi_pend_r  <= nmi_pend_nxt;
            msg_valid_r <= msg_valid_nxt;
            msg_type_r  <= msg_type_nxt;
        end
    end

    assign msg_valid_o       = msg_valid_r;
    assign msg_type_o        = msg_type_r;
    assign apic_pic_intr_o   = pic_intr_i & apic_en; // RL8
    assign apic_win_accept_o = apic_win_access_i & apic_en; // RL7

    // The share-on-pin-D control is a bit of another bridge register, so it
    // arrives as a level. Misc A bits must stay low, so none of them may steer
    // the pins; misc A is plain storage here.
    iopfc_pin_route u_pin_route (
        .ref_clk_i            (ref_clk_i),
        .rst_n_i              (rst_n_i),
        .mp_gpio_route_en_i   (route_cfg_r[iopfc_pkg::BIT_MP_ROUTE]),
        .share_all_on_pin_d_i (share_all_on_pin_d_i),
        .redir_mask_i         (redir_mask_i),
        .gpio_raw_i           (gpio_raw_i),
        .int_src_i            (int_src_i),
        .pci_int_pins_n_o     (pci_int_pins_n_o),
        .pci_int_pins_n_oe_o  (pci_int_pins_n_oe_o)
    );

    // Per-master prefetch fields; group seven is the peripheral pair.
    genvar g;
    generate
        for (g = 0; g < iopfc_pkg::NUM_MASTERS; g++) begin : g_grp
            assign pf_disable_o[g] = pf_lo_r[g*iopfc_pkg::GRP_W + iopfc_pkg::PF_DISABLE_POS]; // RL11 RL12
            assign dis_host[g]     = pf_lo_r[g*iopfc_pkg::GRP_W + iopfc_pkg::PF_HOST_POS]; // RL11
            assign dis_peer[g]     = pf_lo_r[g*iopfc_pkg::GRP_W + iopfc_pkg::PF_PEER_POS]; // RL11
        end
    endgenerate

    logic [1:0] dw_r;
    logic [1:0] dw_nxt;
    logic       pf_r;
    logic       pf_nxt;
    logic [7:0] discard_r;
    logic [7:0] discard_nxt;
    logic [7:0] peer_hit;

    // Only the request size, prefetch flag and discard mask are decided here; the cacheline prefetch engine
    // and the next-doubleword exception on discard belong to the bridge.
    always_comb begin
        peer_hit = 8'h00;
        if (peer_req_i) begin
            peer_hit = dis_peer;
            // A peer request never discards the requester's own data.
            peer_hit[peer_master_i] = 1'b0;
        end
        discard_nxt = peer_hit;
        if (host_req_on_pci_i) begin
            discard_nxt = discard_nxt | dis_host; // RL16
        end
        dw_nxt = dw_r;
        pf_nxt = 1'b0;
        if (rd_req_i) begin
            if (!rd_burst_i) begin
                dw_nxt = iopfc_pkg::DW_SINGLE; // RL15
            end else if (pf_disable_o[rd_master_i]) begin
                dw_nxt = iopfc_pkg::DW_PAIR; // RL15
            end else begin
                dw_nxt = 2'h0;
                pf_nxt = 1'b1; // RL15
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dw_r      <= 2'h0;
            pf_r      <= 1'b0;
            discard_r <= 8'h00;
        end else begin
            dw_r      <= dw_nxt;
            pf_r      <= pf_nxt;
            discard_r <= discard_nxt;
        end
    end

    assign rd_dwords_o   = dw_r;
    assign rd_prefetch_o = pf_r;
    assign pf_discard_o  = discard_r;
endmodule

// ---- core/iopfc_pin_route.sv ----
// Purpose: Drives the four open-drain PCI interrupt pins from GPIO and internal sources.
// Assumes: GPIO levels are the raw pad levels, synchronous to the clock.
// Notes:   Enables come from flip-flops so the pads never see decode glitches.
`timescale 1ns/100ps
module iopfc_pin_route (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       mp_gpio_route_en_i,
    input  wire logic       share_all_on_pin_d_i,
    input  wire logic [3:0] redir_mask_i,
    input  wire logic [3:0] gpio_raw_i,
    input  wire logic [3:0] int_src_i,
    output logic      [3:0] pci_int_pins_n_o,
    output logic      [3:0] pci_int_pins_n_oe_o
);
    logic [3:0] gpio_act;
    logic [3:0] per_pin;
    logic [3:0] oe_r;
    logic [3:0] oe_nxt;

    // Bit n pairs GPIO 28+n with redirection entry 20+n and pin A+n.
    assign gpio_act = {4{mp_gpio_route_en_i}} & redir_mask_i & ~gpio_raw_i; // RL3 RL4 RL5

    always_comb begin
        per_pin = gpio_act | int_src_i;
        if (share_all_on_pin_d_i) begin
            oe_nxt = 4'h0; // RL6 RL14
            oe_nxt[iopfc_pkg::PIN_D] = |per_pin; // RL6 RL14
        end else begin
            oe_nxt = per_pin; // RL14
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            oe_r <= 4'h0;
        end else begin
            oe_r <= oe_nxt;
        end
    end

    // The pins are only ever pulled low; release means high impedance.
    assign pci_int_pins_n_o    = 4'h0; // RL3
    assign pci_int_pins_n_oe_o = oe_r;
endmodule

// ---- core/iopfc_pkg.sv ----
// Purpose: Shared constants of the interrupt routing and prefetch configuration bank.
// Assumes: Byte offsets on the plain register port; data sits in the low bits.
// Notes:   Write masks clear reserved bits so they store nothing and read zero.
package iopfc_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam int          NUM_PINS        = 4;
    localparam int          NUM_MASTERS     = 8;
    localparam int          GRP_W           = 3;

    localparam logic [7:0]  OFS_TAG_CFG     = 8'h4A;
    localparam logic [7:0]  OFS_ROUTE_CFG   = 8'h4B;
    localparam logic [7:0]  OFS_MISC_A      = 8'h4C;
    localparam logic [7:0]  OFS_PF_LO       = 8'h50;
    localparam logic [7:0]  OFS_MISC_B      = 8'h58;

    localparam logic [7:0]  RST_TAG_CFG     = 8'h00;
    localparam logic [7:0]  RST_ROUTE_CFG   = 8'h00;
    localparam logic [15:0] RST_MISC_A      = 16'h0000;
    localparam logic [15:0] RST_MISC_B      = 16'hC000;
    localparam logic [31:0] RST_PF_LO       = 32'h0000_0000;

    localparam logic [7:0]  WMASK_TAG_CFG   = 8'h03;
    localparam logic [7:0]  WMASK_ROUTE_CFG = 8'hFB;
    localparam logic [15:0] WMASK_MISC_A    = 16'h1FFF;
    localparam logic [15:0] WMASK_MISC_B    = 16'hFFFF;
    localparam logic [31:0] WMASK_PF_LO     = 32'h00FF_FFFF;

    localparam int          BIT_INTR_TAG    = 0;
    localparam int          BIT_NMI_TAG     = 1;
    localparam int          BIT_APIC_EN     = 0;
    localparam int          BIT_MP_ROUTE    = 7;

    localparam int          PF_DISABLE_POS  = 0;
    localparam int          PF_HOST_POS     = 1;
    localparam int          PF_PEER_POS     = 2;
    localparam logic [2:0]  PERIPH_GROUP    = 3'h7;

    localparam logic [3:0]  MSG_TYPE_INTR   = 4'h1;
    localparam logic [3:0]  MSG_TYPE_NMI    = 4'h2;
    localparam int          MSG_TAG_BIT     = 3;

    localparam logic [1:0]  DW_SINGLE       = 2'h1;
    localparam logic [1:0]  DW_PAIR         = 2'h2;
    localparam int          PIN_D           = 3;
endpackage

// ---- sim/iopfc_checker.sv ----
// Purpose: Port-level assertions for the interrupt routing and prefetch configuration bank.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes:   Register contents are not shadowed here, so only enable-independent relations are checked.
`timescale 1ns/100ps
module iopfc_checker (
    input wire logic        ref_clk_i,
    input wire logic        rst_n_i,
    input wire logic        reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic        pic_intr_i,
    input wire logic        apic_msg_valid_i,
    input wire logic [3:0]  apic_msg_type_i,
    input wire logic        msg_valid_o,
    input wire logic [3:0]  msg_type_o,
    input wire logic        apic_pic_intr_o,
    input wire logic        apic_win_access_i,
    input wire logic        apic_win_accept_o,
    input wire logic [3:0]  gpio_raw_i,
    input wire logic [3:0]  int_src_i,
    input wire logic        share_all_on_pin_d_i,
    input wire logic [3:0]  pci_int_pins_n_o,
    input wire logic [3:0]  pci_int_pins_n_oe_o,
    input wire logic        rd_req_i,
    input wire logic        rd_burst_i,
    input wire logic [1:0]  rd_dwords_o,
    input wire logic        rd_prefetch_o,
    input wire logic        host_req_on_pci_i,
    input wire logic        peer_req_i,
    input wire logic [7:0]  pf_discard_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_single_rd;
        rd_req_i && !rd_burst_i;
    endsequence
    sequence s_no_discard_cause;
        !host_req_on_pci_i && !peer_req_i && !rd_req_i;
    endsequence
    a_win_gate: assert property (!apic_win_access_i |-> !apic_win_accept_o)
        else $error("window accepted without an access");
    a_pic_gate: assert property (!pic_intr_i |-> !apic_pic_intr_o)
        else $error("PIC level forwarded while low");
    a_rd_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data outside its cycle");
    a_apic_msg_pass: assert property (apic_msg_valid_i |=> msg_valid_o && msg_type_o == $past(apic_msg_type_i))
        else $error("IOAPIC message not passed unchanged");
    a_oe_quiet: assert property (&gpio_raw_i && int_src_i == 4'h0 |=> pci_int_pins_n_oe_o == 4'h0)
        else $error("pin pulled low without a cause");
    a_pins_low: assert property (pci_int_pins_n_o == 4'h0)
        else $error("pin driven high");
    a_share_pin_d: assert property (share_all_on_pin_d_i |=> pci_int_pins_n_oe_o[2:0] == 3'h0)
        else $error("shared interrupt left off pin D");
    a_rd_single: assert property (s_single_rd |=> rd_dwords_o == 2'h1 && !rd_prefetch_o)
        else $error("non-burst read not one doubleword");
    a_no_discard: assert property (s_no_discard_cause |=> pf_discard_o == 8'h00)
        else $error("discard without a request");
endmodule
bind iopfc_cfg iopfc_checker u_chk (.ref_clk_i, .rst_n_i, .reg_rd_i, .reg_rdata_o, .pic_intr_i, .apic_msg_valid_i,
    .apic_msg_type_i, .msg_valid_o, .msg_type_o, .apic_pic_intr_o, .apic_win_access_i, .apic_win_accept_o,
    .gpio_raw_i, .int_src_i, .pci_int_pins_n_o, .pci_int_pins_n_oe_o, .rd_req_i, .rd_burst_i, .rd_dwords_o,
    .rd_prefetch_o, .host_req_on_pci_i, .peer_req_i, .pf_discard_o, .share_all_on_pin_d_i);

// ---- sim/iopfc_host_model.sv ----
// Purpose: Host end of the upstream interrupt message link.
// Assumes: Messages are one-cycle pulses with the type beside them.
// Notes:   The host never stalls, so a lost pulse shows as a short count.
`timescale 1ns/100ps
module iopfc_host_model (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       msg_valid_i,
    input  wire logic [3:0] msg_type_i,
    output logic      [7:0] msg_cnt_o,
    output logic      [3:0] last_type_o
);
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            msg_cnt_o   <= 8'h00;
            last_type_o <= 4'h0;
        end else if (msg_valid_i) begin
            msg_cnt_o   <= msg_cnt_o + 8'h01;
            last_type_o <= msg_type_i;
        end
    end
endmodule

// ---- sim/tb.sv ----
// Purpose: Register, message, pin and prefetch tests of the configuration bank.
// Assumes: Plain register port with read data one cycle after the strobe.
// Notes:   Peer discard is checked with the requesting master excluded.
`timescale 1ns/100ps
module tb;
    logic        ref_clk_i, rst_n_i, reg_wr_i, reg_rd_i, pic_intr_i, local_nmi_i, apic_msg_valid_i;
    logic        apic_win_access_i, rd_req_i, rd_burst_i, host_req_on_pci_i, peer_req_i, share_all_on_pin_d_i;
    logic        msg_valid_o, apic_pic_intr_o, apic_win_accept_o, rd_prefetch_o;
    logic [1:0]  rd_dwords_o;
    logic [2:0]  rd_master_i, peer_master_i;
    logic [3:0]  apic_msg_type_i, redir_mask_i, gpio_raw_i, int_src_i, msg_type_o, last_type;
    logic [3:0]  pci_int_pins_n_o, pci_int_pins_n_oe_o;
    logic [7:0]  reg_addr_i, pf_discard_o, pf_disable_o, msg_cnt, cnt0;
    logic [31:0] reg_wdata_i, reg_rdata_o;
    int          miscompares, n_checks;
    logic [7:0]  ofs [5] = '{8'h4A, 8'h4B, 8'h4C, 8'h50, iopfc_pkg::OFS_MISC_B};
    logic [31:0] rv  [5] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_C000};
    logic [31:0] wm  [5] = '{32'(iopfc_pkg::WMASK_TAG_CFG), 32'(iopfc_pkg::WMASK_ROUTE_CFG),
                            32'(iopfc_pkg::WMASK_MISC_A), iopfc_pkg::WMASK_PF_LO, 32'(iopfc_pkg::WMASK_MISC_B)};
    iopfc_cfg dut (.ref_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .pic_intr_i, .local_nmi_i, .apic_msg_valid_i, .apic_msg_type_i, .msg_valid_o, .msg_type_o,
        .apic_pic_intr_o, .apic_win_access_i, .apic_win_accept_o, .redir_mask_i, .gpio_raw_i, .int_src_i,
        .share_all_on_pin_d_i,
        .pci_int_pins_n_o, .pci_int_pins_n_oe_o, .rd_req_i, .rd_master_i, .rd_burst_i, .rd_dwords_o,
        .rd_prefetch_o, .host_req_on_pci_i, .peer_req_i, .peer_master_i, .pf_discard_o, .pf_disable_o);
    iopfc_host_model host (.ref_clk_i, .rst_n_i, .msg_valid_i(msg_valid_o), .msg_type_i(msg_type_o),
        .msg_cnt_o(msg_cnt), .last_type_o(last_type));
    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    task automatic test_done;
        if (miscompares == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i    <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i   <= 1'b0;
        #1;
        chk("reg_rdata_o", e, reg_rdata_o);
    endtask
    task automatic pins(input logic [3:0] m, input logic [3:0] g, input logic [3:0] s, input logic [3:0] e);
        @(posedge ref_clk_i);
        redir_mask_i <= m;
        gpio_raw_i   <= g;
        int_src_i    <= s;
        tick(3);
        chk("pci_int_pins_n_oe_o", 32'(e), 32'(pci_int_pins_n_oe_o));
    endtask
    task automatic pf(input logic [2:0] m, input logic b, input logic [1:0] e, input logic p);
        @(posedge ref_clk_i);
        rd_req_i    <= 1'b1;
        rd_master_i <= m;
        rd_burst_i  <= b;
        @(posedge ref_clk_i);
        rd_req_i    <= 1'b0;
        #1;
        chk("rd_dwords_o", 32'(e), 32'(rd_dwords_o));
        chk("rd_prefetch_o", 32'(p), 32'(rd_prefetch_o));
    endtask
    task automatic msg(input logic n, input logic [3:0] e);
        @(posedge ref_clk_i);
        local_nmi_i <= n;
        pic_intr_i  <= !n;
        tick(5);
        chk("last_type", 32'(e), 32'(last_type));
        @(posedge ref_clk_i);
        local_nmi_i <= 1'b0;
        pic_intr_i  <= 1'b0;
        tick(2);
    endtask
    initial begin
        #20000;
        miscompares++;
        test_done();
    end
    initial begin
        {rst_n_i, reg_wr_i, reg_rd_i, pic_intr_i, local_nmi_i, apic_msg_valid_i} = '0;
        {apic_win_access_i, rd_req_i, rd_burst_i, host_req_on_pci_i, peer_req_i, share_all_on_pin_d_i} = '0;
        {rd_master_i, peer_master_i, apic_msg_type_i, redir_mask_i, int_src_i} = '0;
        {reg_addr_i, reg_wdata_i} = '0;
        gpio_raw_i = 4'hF;
        repeat (20) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 5; i++) rd_chk(ofs[i], rv[i]);
        rd_chk(8'h60, 32'h0);
        for (int i = 0; i < 5; i++) begin
            wr(ofs[i], 32'hFFFF_FFFF);
            rd_chk(ofs[i], wm[i]);
            wr(ofs[i], 32'h0);
            rd_chk(ofs[i], 32'h0);
        end
        for (int g = 0; g < 8; g++) begin
            wr(8'h50, 32'h1 << (3 * g));
            tick(1);
            chk("pf_disable_o", 32'h1 << g, 32'(pf_disable_o));
        end
        // Group 2 prefetch off, group 4 discards on host requests.
        wr(8'h50, 32'h0000_2040);
        pf(3'h2, 1'b1, iopfc_pkg::DW_PAIR, 1'b0);
        pf(3'h3, 1'b1, 2'h0, 1'b1);
        pf(3'h3, 1'b0, iopfc_pkg::DW_SINGLE, 1'b0);
        @(posedge ref_clk_i);
        host_req_on_pci_i <= 1'b1;
        @(posedge ref_clk_i);
        host_req_on_pci_i <= 1'b0;
        #1;
        chk("pf_discard_o", 32'h10, 32'(pf_discard_o));
        // Peer discard in groups 1 and 4; requester 4 keeps its own data.
        wr(8'h50, 32'h0000_4020);
        @(posedge ref_clk_i);
        peer_req_i    <= 1'b1;
        peer_master_i <= 3'h4;
        @(posedge ref_clk_i);
        peer_req_i    <= 1'b0;
        #1;
        chk("pf_discard_o", 32'h02, 32'(pf_discard_o));
        wr(8'h4A, 32'h3);
        msg(1'b1, iopfc_pkg::MSG_TYPE_NMI | 4'h8);
        msg(1'b0, iopfc_pkg::MSG_TYPE_INTR | 4'h8);
        @(posedge ref_clk_i);
        apic_msg_valid_i <= 1'b1;
        apic_msg_type_i  <= 4'h5;
        @(posedge ref_clk_i);
        apic_msg_valid_i <= 1'b0;
        tick(3);
        chk("last_type", 32'h5, 32'(last_type));
        wr(8'h4A, 32'h0);
        msg(1'b1, iopfc_pkg::MSG_TYPE_NMI);
        msg(1'b0, iopfc_pkg::MSG_TYPE_INTR);
        wr(8'h4B, 32'h1);
        cnt0 = msg_cnt;
        @(posedge ref_clk_i);
        pic_intr_i        <= 1'b1;
        apic_win_access_i <= 1'b1;
        tick(5);
        chk("apic_pic_intr_o", 32'h1, 32'(apic_pic_intr_o));
        chk("apic_win_accept_o", 32'h1, 32'(apic_win_accept_o));
        chk("msg_cnt", 32'(cnt0), 32'(msg_cnt));
        wr(8'h4B, 32'h0);
        tick(1);
        chk("apic_win_accept_o", 32'h0, 32'(apic_win_accept_o));
        apic_win_access_i <= 1'b0;
        wr(8'h4B, 32'h80);
        pic_intr_i        <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            pins(4'hF, ~(4'h1 << i), 4'h0, 4'h1 << i);
            pins(4'hF, 4'hF, 4'h1 << i, 4'h1 << i);
        end
        pins(4'hE, 4'hE, 4'h0, 4'h0);
        @(posedge ref_clk_i);
        share_all_on_pin_d_i <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            pins(4'hF, ~(4'h1 << i), 4'h0, 4'h8);
            pins(4'hF, 4'hF, 4'h1 << i, 4'h8);
        end
        wr(8'h4B, 32'h0);
        pins(4'hF, 4'h0, 4'h0, 4'h0);
        test_done();
    end
endmodule
